//--- rtl/corc_pkg.sv
// package: mode word layout, reset value, command strobes and state carrier
package corc_pkg;
    localparam int          CNT_W           = 16;
    localparam logic [15:0] MODE_RESET      = 16'h0800;
    localparam int          OUT_CTL_LSB     = 0;
    localparam int          DIR_POS         = 3;
    localparam int          DEC_POS         = 4;
    localparam int          REPEAT_POS      = 5;
    localparam int          RELOAD_SRC_POS  = 6;
    localparam int          SPECIAL_POS     = 7;
    localparam int          GATE_FLD_LSB    = 13;
    localparam logic [15:0] TERM_DOWN       = 16'h0001;
    localparam logic [15:0] TERM_BCD_UP     = 16'h9999;
    localparam logic [15:0] TERM_BIN_UP     = 16'hFFFF;
    // code 0 is the preset drive: low to ground, so the pin never floats out of reset
    localparam logic [2:0]  OUT_HIZ         = 3'h4;
    localparam logic [2:0]  OUT_TC_HIGH     = 3'h1;
    localparam logic [2:0]  OUT_TOGGLE      = 3'h2;
    localparam logic [2:0]  OUT_LOW         = 3'h0;
    localparam logic [2:0]  OUT_TC_LOW      = 3'h5;
    localparam logic [2:0]  GATE_NONE       = 3'h0;
    localparam logic [2:0]  GATE_LVL_HI     = 3'h4;
    localparam logic [2:0]  GATE_LVL_LO     = 3'h5;
    localparam logic [2:0]  GATE_EDGE_RISE  = 3'h6;
    localparam logic [2:0]  GATE_EDGE_FALL  = 3'h7;

    // one-cycle command strobes from the command decoder
    typedef struct packed {
        logic arm;
        logic load;
        logic loadArm;
        logic disarm;
        logic save;
        logic step;
        logic setOut;
        logic clrOut;
        logic masterReset;
        logic modeWrite;
    } corc_cmd_t;

    // whole block state
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] count;
        logic [15:0] hold;
        logic        armed;
        logic        tc;
        logic        toggle;
        logic        retrigPend;
        logic        useHold;
        logic        tcSeen;
        logic        started;
        logic [2:0]  srcSync;
        logic [2:0]  gateSync;
        logic        srcLvl;
        logic        gateLvl;
        logic        outData;
        logic        outEn;
    } corc_state_t;
endpackage

//--- rtl/corc_counter.sv
// counter output, terminal count, reload and retrigger logic of one counter
module corc_counter (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    // pins
    input  wire logic                  srcPin,
    input  wire logic                  gatePin,
    output logic                       outPin,
    output logic                       outPinEn,
    // host side
    input  wire corc_pkg::corc_cmd_t   cmd,
    input  wire logic [15:0]           modeWdata,
    input  wire logic [15:0]           loadReg,
    output logic [15:0]                counter_mode_word,
    output logic [15:0]                countValue,
    output logic [15:0]                holdValue,
    output logic                       terminal_count,
    output logic                       armedFlag
);
    import corc_pkg::*;

    corc_state_t r, nxt;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] stepVal(input logic [15:0] v, input logic up, input logic dec);
        logic [15:0] res;
        logic        carry;
        res   = v;
        carry = 1'b1;
        if (!dec) begin
            res = up ? v + 16'h0001 : v - 16'h0001;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (carry) begin
                    if (up) begin
                        carry = (v[i*4 +: 4] == 4'h9);
                        res[i*4 +: 4] = carry ? 4'h0 : v[i*4 +: 4] + 4'h1;
                    end else begin
                        carry = (v[i*4 +: 4] == 4'h0);
                        res[i*4 +: 4] = carry ? 4'h9 : v[i*4 +: 4] - 4'h1;
                    end
                end
            end
        end
        return res;
    endfunction

    function automatic logic isTerm(input logic [15:0] v, input logic up, input logic dec);
        if (!up) begin
            return v == TERM_DOWN;
        end else begin
            return v == (dec ? TERM_BCD_UP : TERM_BIN_UP);
        end
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic [2:0]  outCtl;
    logic [2:0]  gateFld;
    logic        dirUp;
    logic        decMode;
    logic        repeatOn;
    logic        reloadSrc;
    logic        special;
    logic        srcEdge;
    logic        gateEdge;
    logic        gateActive;
    logic        gatedOn;
    logic        edgeGating;
    logic        cmdLoad;
    logic        advance;
    logic        committed;
    logic        doCount;
    logic        reloadHold;
    logic [15:0] reloadVal;

    always_comb begin
        nxt        = r;
        outCtl     = r.mode[OUT_CTL_LSB +: 3];
        gateFld    = r.mode[GATE_FLD_LSB +: 3];
        dirUp      = r.mode[DIR_POS];
        decMode    = r.mode[DEC_POS];
        repeatOn   = r.mode[REPEAT_POS];
        reloadSrc  = r.mode[RELOAD_SRC_POS];
        special    = r.mode[SPECIAL_POS];
        // synchronous edge detection on agreeing stages
        nxt.srcSync  = {r.srcSync[1:0], srcPin};
        nxt.gateSync = {r.gateSync[1:0], gatePin};
        if (r.srcSync[2] == r.srcSync[1]) begin
            nxt.srcLvl = r.srcSync[2];
        end
        if (r.gateSync[2] == r.gateSync[1]) begin
            nxt.gateLvl = r.gateSync[2];
        end
        srcEdge    = nxt.srcLvl & ~r.srcLvl;
        edgeGating = (gateFld == GATE_EDGE_RISE) || (gateFld == GATE_EDGE_FALL);
        gateActive = (gateFld == GATE_LVL_LO || gateFld == GATE_EDGE_FALL) ? ~nxt.gateLvl : nxt.gateLvl;
        gateEdge   = (gateFld == GATE_LVL_LO || gateFld == GATE_EDGE_FALL)
                   ? (~nxt.gateLvl & r.gateLvl) : (nxt.gateLvl & ~r.gateLvl);
        gatedOn    = (gateFld == GATE_NONE) ? 1'b1 : (edgeGating ? r.started : gateActive);
        cmdLoad    = cmd.load | cmd.loadArm;
        // terminal value in the counter commits the next count
        committed  = isTerm(r.count, dirUp, decMode);
        // an active terminal count always takes the next edge
        doCount    = srcEdge & ((r.armed & gatedOn) | r.tc);
        // step always counts as an edge; load only when committed or in tc
        advance    = doCount | cmd.step | (cmdLoad & (committed | r.tc));
        if (!reloadSrc) begin
            reloadHold = 1'b0;
        end else if (gateFld == GATE_NONE && special) begin
            reloadHold = nxt.gateLvl;
        end else begin
            reloadHold = r.useHold;
        end
        reloadVal  = reloadHold ? r.hold : loadReg;

        if (cmd.save) begin
            nxt.hold = r.count;
        end
        if (cmd.arm | cmd.loadArm) begin
            nxt.armed  = 1'b1;
            nxt.tcSeen = 1'b0;
        end
        if (cmd.disarm) begin
            nxt.armed   = 1'b0;
            nxt.started = 1'b0;
        end
        if (edgeGating && gateEdge && r.armed) begin
            nxt.started = 1'b1;
        end
        // retrigger saves count, arms pending reload
        if (gateFld != GATE_NONE && special && gateEdge && (r.armed || !edgeGating)) begin
            nxt.hold       = r.count;
            nxt.retrigPend = 1'b1;
        end

        if (advance && committed) begin
            nxt.tc         = 1'b1;
            nxt.count      = reloadVal;
            nxt.useHold    = reloadSrc & ~r.useHold;
            nxt.retrigPend = 1'b0;
        end else if (cmdLoad && r.tc) begin
            // load during terminal count ends it
            nxt.tc    = 1'b0;
            nxt.count = stepVal(reloadVal, dirUp, decMode);
        end else if (r.retrigPend && (doCount || cmd.step || cmdLoad)) begin
            // first qualified edge or command reloads from Load
            nxt.count      = loadReg;
            nxt.retrigPend = 1'b0;
            nxt.tc         = 1'b0;
        end else if (cmdLoad) begin
            nxt.count = reloadVal;
        end else if (advance) begin
            // terminal count ends at the next count
            nxt.count = stepVal(r.count, dirUp, decMode);
            nxt.tc    = 1'b0;
        end

        // toggle on trailing edge of terminal count
        if (r.tc && !nxt.tc) begin
            nxt.toggle = ~r.toggle;
            // one-shot: disarm after the edge ending a full cycle
            if (!repeatOn && (r.tcSeen || !reloadSrc)) begin
                nxt.armed   = 1'b0;
                nxt.started = 1'b0;
            end
            nxt.tcSeen = ~r.tcSeen;
        end else if (r.tc && advance) begin
            // stays in terminal count, toggle on every count
            nxt.toggle = ~r.toggle;
        end
        if (cmd.setOut) begin
            nxt.toggle = 1'b1;
        end
        if (cmd.clrOut) begin
            nxt.toggle = 1'b0;
        end
        if (cmd.modeWrite) begin
            nxt.mode = modeWdata;
        end
        // master reset presets the mode word
        if (cmd.masterReset) begin
            nxt.mode    = MODE_RESET;
            nxt.armed   = 1'b0;
            nxt.started = 1'b0;
        end

        unique case (nxt.mode[OUT_CTL_LSB +: 3])
            OUT_TC_HIGH: begin
                nxt.outData = nxt.tc;
                nxt.outEn   = 1'b1;
            end
            OUT_TC_LOW: begin
                nxt.outData = ~nxt.tc;
                nxt.outEn   = 1'b1;
            end
            OUT_TOGGLE: begin
                nxt.outData = nxt.toggle;
                nxt.outEn   = 1'b1;
            end
            OUT_LOW: begin
                nxt.outData = 1'b0;
                nxt.outEn   = 1'b1;
            end
            default: begin
                // reserved codes are treated as off
                nxt.outData = 1'b0;
                nxt.outEn   = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r          <= '0;
            // power-on preset
            // preset output code drives low, so the enable starts high
            r.mode     <= MODE_RESET;
            r.outEn    <= 1'b1;
        end else begin
            r <= nxt;
        end
    end

    assign outPin            = r.outData;
    assign outPinEn          = r.outEn;
    assign counter_mode_word = r.mode;
    assign countValue        = r.count;
    assign holdValue         = r.hold;
    assign terminal_count    = r.tc;
    assign armedFlag         = r.armed;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_tc_entry: assert property (@(posedge core_clk) disable iff (!nrst)
        (advance && committed) |=> r.tc) else $error("terminal count not entered");
    chk_tc_reload: assert property (@(posedge core_clk) disable iff (!nrst)
        (advance && committed && !reloadHold) |=> (r.count == $past(loadReg))) else $error("reload wrong");
    chk_tc_width: assert property (@(posedge core_clk) disable iff (!nrst)
        (r.tc && srcEdge && !committed && !r.retrigPend) |=> !r.tc) else $error("terminal count too long");
    chk_toggle_flip: assert property (@(posedge core_clk) disable iff (!nrst)
        (r.tc && !nxt.tc && !cmd.setOut && !cmd.clrOut) |=> (r.toggle != $past(r.toggle)))
        else $error("toggle missed");
    chk_toggle_force: assert property (@(posedge core_clk) disable iff (!nrst)
        (cmd.setOut && !cmd.clrOut) |=> r.toggle) else $error("set output failed");
    chk_out_low: assert property (@(posedge core_clk) disable iff (!nrst)
        (outCtl == OUT_LOW) |-> (outPinEn && !outPin)) else $error("output not low");
    chk_out_hiz: assert property (@(posedge core_clk) disable iff (!nrst)
        (outCtl == OUT_HIZ) |-> !outPinEn) else $error("output not off");
    chk_load_commit: assert property (@(posedge core_clk) disable iff (!nrst)
        (cmd.load && committed && !r.tc) |=> r.tc) else $error("load did not force tc");
    chk_master_reset: assert property (@(posedge core_clk) disable iff (!nrst)
        cmd.masterReset |=> (r.mode == MODE_RESET)) else $error("mode not preset");
    chk_retrig_save: assert property (@(posedge core_clk) disable iff (!nrst)
        (gateFld != GATE_NONE && special && gateEdge && !edgeGating && !cmd.save
         && !(advance && committed) && !r.retrigPend)
        |=> r.retrigPend && (r.hold == $past(r.count))) else $error("retrigger not saved");
    chk_tc_counts: assert property (@(posedge core_clk) disable iff (!nrst)
        (r.tc && srcEdge && !committed && !cmdLoad && !r.retrigPend) |=> (r.count != $past(r.count)))
        else $error("edge in terminal count not counted");

    cov_tc: cover property (@(posedge core_clk) disable iff (!nrst) r.tc ##1 !r.tc);
    cov_retrig: cover property (@(posedge core_clk) disable iff (!nrst) r.retrigPend ##[1:20] !r.retrigPend);
    cov_oneshot: cover property (@(posedge core_clk) disable iff (!nrst) r.armed ##1 !r.armed);
    cov_stuck_tc: cover property (@(posedge core_clk) disable iff (!nrst) r.tc && advance && committed);
    cov_retrig_step: cover property (@(posedge core_clk) disable iff (!nrst) r.retrigPend && cmd.step);
endmodule

//--- dv/corc_pin_model.sv
// partner model: external source and gate pins of one counter
module corc_pin_model (
    // clock
    input  wire logic core_clk,
    // driven pins
    output logic      srcPin,
    output logic      gatePin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        srcPin = 1'b0;
        gatePin = 1'b0;
    end
    // ----------------------------------------
    // pin stimulus
    // ----------------------------------------
    // w sets the pace; high and low both outlast the three-flop synchroniser
    task automatic pulse(input int n, input int w);
        repeat (n) begin
            @(posedge core_clk) srcPin <= 1'b1;
            repeat (w) @(posedge core_clk);
            srcPin <= 1'b0;
            repeat (w + 4) @(posedge core_clk);
        end
    endtask
    // gate level change, held until the synchronised edge has landed
    task automatic setGate(input logic v);
        @(posedge core_clk) gatePin <= v;
        repeat (8) @(posedge core_clk);
    endtask
endmodule

//--- dv/counter_output_reload_control_tb.sv
// testbench: scenarios for the counter output, terminal count and reload block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module counter_output_reload_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import corc_pkg::*;
    localparam logic [9:0] C_ARM = 10'h200;
    localparam logic [9:0] C_LOAD = 10'h100;
    localparam logic [9:0] C_DIS = 10'h040;
    localparam logic [9:0] C_STEP = 10'h010;
    localparam logic [9:0] C_SET = 10'h008;
    localparam logic [9:0] C_CLR = 10'h004;
    localparam logic [9:0] C_MRST = 10'h002;
    localparam logic [9:0] C_MWR = 10'h001;
    logic        core_clk, nrst, srcPin, gatePin, outPin, outPinEn, tcFlag, armed;
    corc_cmd_t   cmd;
    logic [15:0] modeWdata, loadReg, modeWord, countVal, holdVal;
    int          n_fail, check_count;

    corc_pin_model pm (.core_clk(core_clk), .srcPin(srcPin), .gatePin(gatePin));
    corc_counter dut (.core_clk(core_clk), .nrst(nrst), .srcPin(srcPin), .gatePin(gatePin),
        .outPin(outPin), .outPinEn(outPinEn), .cmd(cmd), .modeWdata(modeWdata),
        .loadReg(loadReg), .counter_mode_word(modeWord), .countValue(countVal),
        .holdValue(holdVal), .terminal_count(tcFlag), .armedFlag(armed));

    always #2 core_clk = ~core_clk;
    // ----------------------------------------
    // shared drivers
    // ----------------------------------------
    task automatic go(input logic [9:0] m);
        @(posedge core_clk) cmd <= corc_cmd_t'(m);
        @(posedge core_clk) cmd <= '0;
        @(negedge core_clk);
    endtask
    task automatic src(input int n);
        pm.pulse(n, 4);
        @(negedge core_clk);
    endtask
    // an open terminal count is ended first, else the load would count one;
    // new reload value goes in first so a stuck terminal count can leave
    task automatic start(input logic [15:0] m, input logic [15:0] ld);
        @(posedge core_clk) loadReg <= ld;
        go(C_DIS);
        for (int k = 0; k < 2; k++) begin
            if (tcFlag === 1'b1) src(1);
        end
        @(posedge core_clk) modeWdata <= m;
        go(C_MWR);
        go(C_CLR);
        go(C_LOAD);
        go(C_ARM);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_walk();
        start(16'h0022, 16'h0003);
        `CHK(countVal, 16'h0003)
        src(2);
        `CHK({tcFlag, countVal}, {1'b0, 16'h0001})
        src(1);
        `CHK({tcFlag, countVal, outPin}, {1'b1, 16'h0003, 1'b0})
        src(1);
        `CHK({tcFlag, countVal, outPin}, {1'b0, 16'h0002, 1'b1})
        src(1);
        @(posedge core_clk) loadReg <= 16'h0005;
        go(C_LOAD);
        `CHK({tcFlag, countVal}, {1'b1, 16'h0005})
        go(C_LOAD);
        `CHK({tcFlag, countVal, outPin}, {1'b0, 16'h0004, 1'b0})
    endtask
    task automatic t_force();
        go(C_SET);
        `CHK(outPin, 1'b1)
        go(C_SET | C_CLR);
        `CHK(outPin, 1'b0)
        go(C_SET);
        go(C_CLR);
        `CHK(outPin, 1'b0)
    endtask
    task automatic t_codes();
        logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
        logic [1:0] expv [4] = '{2'b10, 2'b10, 2'b00, 2'b11};
        go(C_DIS);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk) modeWdata <= {13'h0000, codes[i]};
            go(C_MWR);
            `CHK(outPinEn, expv[i][1])
            if (expv[i][1]) `CHK(outPin, expv[i][0])
        end
    endtask
    task automatic t_up();
        start(16'h002D, 16'hFFFE);
        src(1);
        `CHK({tcFlag, countVal}, {1'b0, 16'hFFFF})
        src(1);
        `CHK({tcFlag, countVal, outPin}, {1'b1, 16'hFFFE, 1'b0})
        go(C_DIS);
        src(1);
        `CHK({tcFlag, countVal}, {1'b0, 16'hFFFF})
        start(16'h0039, 16'h9998);
        src(1);
        `CHK(countVal, 16'h9999)
        src(1);
        `CHK({tcFlag, countVal, outPin}, {1'b1, 16'h9998, 1'b1})
    endtask
    task automatic t_oneshot();
        start(16'h0002, 16'h0002);
        pm.pulse(1, 8);
        src(1);
        `CHK({tcFlag, armed}, 2'b11)
        src(1);
        `CHK({tcFlag, armed, countVal}, {2'b00, 16'h0001})
        src(1);
        `CHK(countVal, 16'h0001)
    endtask
    task automatic t_stuck();
        start(16'h0022, 16'h0001);
        `CHK({tcFlag, countVal, outPin}, {1'b1, 16'h0001, 1'b0})
        src(1);
        `CHK({tcFlag, outPin}, 2'b11)
        src(1);
        `CHK({tcFlag, countVal, outPin}, {1'b1, 16'h0001, 1'b0})
        go(C_STEP);
        `CHK({tcFlag, outPin}, 2'b11)
    endtask
    task automatic t_retrig();
        start(16'h80A1, 16'h000A);
        src(1);
        `CHK(countVal, 16'h000A)
        @(posedge core_clk) loadReg <= 16'h0007;
        pm.setGate(1'b1);
        `CHK(holdVal, 16'h000A)
        src(1);
        `CHK(countVal, 16'h0007)
        src(1);
        `CHK(countVal, 16'h0006)
        pm.setGate(1'b0);
        pm.setGate(1'b1);
        go(C_STEP);
        `CHK({holdVal, countVal}, {16'h0006, 16'h0007})
        start(16'h8021, 16'h0009);
        pm.setGate(1'b0);
        pm.setGate(1'b1);
        src(1);
        `CHK({holdVal, countVal}, {16'h0006, 16'h0008})
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        cmd = '0;
        modeWdata = '0;
        loadReg = '0;
        n_fail = 0;
        check_count = 0;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK({modeWord, outPinEn, tcFlag}, {MODE_RESET, 2'b10})
        t_walk();
        t_force();
        t_codes();
        t_up();
        t_oneshot();
        t_stuck();
        t_retrig();
        go(C_MRST);
        `CHK(modeWord, MODE_RESET)
        close_out();
    end
endmodule
